// file: pkg/bpad_params.svh
// Purpose: Offsets, field positions and reset values of the port block.
// Assumes: Addresses are data-memory byte addresses with the bank bits included.
// Notes:   Definitions only.
`ifndef BPAD_PARAMS_SVH
`define BPAD_PARAMS_SVH

// ************************************************************
// Register offsets.
// ************************************************************
`define BPAD_OFS_A_DATA   8'h05
`define BPAD_OFS_D_DATA   8'h08
`define BPAD_OFS_A_DIR    8'h85
`define BPAD_OFS_D_DIR    8'h88
`define BPAD_OFS_E_DIR    8'h89
`define BPAD_OFS_CONV_CFG 8'h9F

// ************************************************************
// Field positions.
// ************************************************************
`define BPAD_A_TMR_BIT    4
`define BPAD_E_PSP_BIT    4
`define BPAD_E_IN_FULL_BIT  7
`define BPAD_E_OUT_FULL_BIT 6
`define BPAD_E_IN_OVF_BIT   5

// ************************************************************
// Reset values.
// ************************************************************
`define BPAD_RST_A_LATCH  6'h00
`define BPAD_RST_A_DIR    6'h3F
`define BPAD_RST_CONV_CFG 5'h1F
`define BPAD_RST_D_LATCH  8'h00
`define BPAD_RST_D_DIR    8'hFF
`define BPAD_RST_E_DIR    3'h7
`define BPAD_RST_PSP      1'h0

`endif

// file: pkg/bpad_pkg.sv
// Purpose: Types shared by the port block.
// Assumes: Constants come from bpad_params.svh.
// Notes:   Field widths follow the fixed port widths.
package bpad_pkg;

    // ************************************************************
    // State of the pin synchroniser.
    // ************************************************************
    typedef struct packed {
        logic [13:0] s1;
        logic [13:0] s2;
        logic [13:0] s3;
        logic [13:0] val;
    } bpad_sync_t;

    // ************************************************************
    // State of the port block.
    // ************************************************************
    typedef struct packed {
        logic [5:0] a_latch;
        logic [5:0] a_dir;
        logic [4:0] conv_cfg;
        logic [7:0] d_latch;
        logic [7:0] d_dir;
        logic [2:0] e_dir;
        logic       psp_en;
        logic [7:0] rdata;
        logic [5:0] a_out;
        logic [5:0] a_oe;
        logic [7:0] d_out;
        logic [7:0] d_oe;
        logic       tmr_clk;
        logic [7:0] psp_byte;
    } bpad_state_t;

endpackage

// file: core/bpad_sync.sv
// Purpose: Three-stage synchroniser for the port pins.
// Assumes: Inputs are asynchronous to sys_clk_i.
// Notes:   A new level is taken once stages two and three agree.
`timescale 1ns/10ps
module bpad_sync
    import bpad_pkg::*;
(
    // Clock and reset.
    input  wire logic        sys_clk_i,
    input  wire logic        rst_i,
    // Pins and synchronised levels.
    input  wire logic [13:0] pin_i,
    output logic      [13:0] level_o
);

    bpad_sync_t  st;
    bpad_sync_t  next_st;
    logic [13:0] next_val_bit;

    // ************************************************************
    // Next state.
    // ************************************************************
    always_comb begin
        next_st     = st;
        next_st.s1  = pin_i;
        next_st.s2  = st.s1;
        next_st.s3  = st.s2;
        next_st.val = next_val_bit;
    end

    for (genvar i = 0; i < 14; i++) begin : g_bit
        assign next_val_bit[i] = (st.s2[i] == st.s3[i]) ? st.s3[i] : st.val[i];
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level_o = st.val;

endmodule

// file: core/bpad_top.sv
// Purpose: General-purpose ports A and D with parallel slave mode on port D.
// Assumes: The CPU data-memory bus gives one access per cycle with a bit mask.
// Notes:   Read data appear one cycle after the read strobe.
`timescale 1ns/10ps
`include "bpad_params.svh"

module bpad_top
    import bpad_pkg::*;
#(
    parameter bit HAS_PORT_DE = 1'b1
)
(
    // Clock and reset.
    input  wire logic       sys_clk_i,
    input  wire logic       rst_i,
    // Data-memory bus.
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] wmask_i,
    output logic      [7:0] rdata_o,
    // Port A pins.
    input  wire logic [5:0] first_port_pin_i,
    output logic      [5:0] first_port_pin_o,
    output logic      [5:0] first_port_pin_oe_o,
    // Port D pins.
    input  wire logic [7:0] fourth_port_pin_i,
    output logic      [7:0] fourth_port_pin_o,
    output logic      [7:0] fourth_port_pin_oe_o,
    // Shared peripheral signals.
    output logic            timer_ext_clock_in_o,
    output logic      [7:0] slave_data_o,
    output logic            parallel_slave_enable_o,
    output logic      [4:0] converter_analog_o
);

    bpad_state_t st;
    bpad_state_t next_st;
    logic [13:0] pin_level;
    logic [5:0]  a_pins;
    logic [7:0]  d_pins;
    logic [5:0]  a_analog;
    logic [5:0]  a_read;
    logic [7:0]  rd_value;
    logic [7:0]  de_gate;

    // ************************************************************
    // Pin synchroniser.
    // ************************************************************
    bpad_sync u_sync (
        .sys_clk_i (sys_clk_i),
        .rst_i     (rst_i),
        .pin_i     ({fourth_port_pin_i, first_port_pin_i}),
        .level_o   (pin_level)
    );

    assign a_pins = pin_level[5:0];
    assign d_pins = pin_level[13:6];

    // ************************************************************
    // Pin readback.
    // ************************************************************
    always_comb begin
        a_analog = {st.conv_cfg[4], 1'b0, st.conv_cfg[3:0]};
        a_read   = a_pins & ~a_analog;
        de_gate  = HAS_PORT_DE ? 8'hFF : 8'h00;
        case (addr_i)
            `BPAD_OFS_A_DATA: begin
                rd_value = {2'h0, a_read};
            end
            `BPAD_OFS_A_DIR: begin
                rd_value = {2'h0, st.a_dir};
            end
            `BPAD_OFS_CONV_CFG: begin
                rd_value = {3'h0, st.conv_cfg};
            end
            `BPAD_OFS_D_DATA: begin
                rd_value = d_pins & de_gate;
            end
            `BPAD_OFS_D_DIR: begin
                rd_value = st.d_dir & de_gate;
            end
            `BPAD_OFS_E_DIR: begin
                rd_value = {3'h0, st.psp_en, 1'h0, st.e_dir} & de_gate;
            end
            default: begin
                rd_value = 8'h00;
            end
        endcase
    end

    // ************************************************************
    // Register writes and pin drive.
    // ************************************************************
    always_comb begin
        next_st = st;
        if (wr_i) begin
            case (addr_i)
                `BPAD_OFS_A_DATA: begin
                    next_st.a_latch = (a_pins & ~wmask_i[5:0]) | (wdata_i[5:0] & wmask_i[5:0]);
                end
                `BPAD_OFS_A_DIR: begin
                    next_st.a_dir = (st.a_dir & ~wmask_i[5:0]) | (wdata_i[5:0] & wmask_i[5:0]);
                end
                `BPAD_OFS_CONV_CFG: begin
                    next_st.conv_cfg = (st.conv_cfg & ~wmask_i[4:0]) | (wdata_i[4:0] & wmask_i[4:0]);
                end
                `BPAD_OFS_D_DATA: begin
                    next_st.d_latch = (d_pins & ~wmask_i) | (wdata_i & wmask_i);
                end
                `BPAD_OFS_D_DIR: begin
                    next_st.d_dir = (st.d_dir & ~wmask_i) | (wdata_i & wmask_i);
                end
                `BPAD_OFS_E_DIR: begin
                    next_st.e_dir = (st.e_dir & ~wmask_i[2:0]) | (wdata_i[2:0] & wmask_i[2:0]);
                    if (wmask_i[`BPAD_E_PSP_BIT]) begin
                        next_st.psp_en = wdata_i[`BPAD_E_PSP_BIT];
                    end
                end
                default: begin
                    next_st.psp_en = st.psp_en;
                end
            endcase
        end
        if (rd_i) begin
            next_st.rdata = rd_value;
        end
        next_st.a_out    = st.a_latch;
        next_st.a_oe     = ~st.a_dir;
        next_st.a_out[`BPAD_A_TMR_BIT] = 1'b0;
        next_st.a_oe[`BPAD_A_TMR_BIT]  = ~st.a_dir[`BPAD_A_TMR_BIT] & ~st.a_latch[`BPAD_A_TMR_BIT];
        next_st.tmr_clk  = a_pins[`BPAD_A_TMR_BIT];
        next_st.d_out    = st.d_latch;
        if (st.psp_en || !HAS_PORT_DE) begin
            next_st.d_oe = 8'h00;
        end else begin
            next_st.d_oe = ~st.d_dir;
        end
        next_st.psp_byte = st.psp_en ? d_pins : st.psp_byte;
    end

    // ************************************************************
    // State register.
    // ************************************************************
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            st          <= '0;
            st.a_latch  <= `BPAD_RST_A_LATCH;
            st.a_dir    <= `BPAD_RST_A_DIR;
            st.conv_cfg <= `BPAD_RST_CONV_CFG;
            st.d_latch  <= `BPAD_RST_D_LATCH;
            st.d_dir    <= `BPAD_RST_D_DIR;
            st.e_dir    <= `BPAD_RST_E_DIR;
            st.psp_en   <= `BPAD_RST_PSP;
        end else begin
            st <= next_st;
        end
    end

    // ************************************************************
    // Outputs.
    // ************************************************************
    assign rdata_o                 = st.rdata;
    assign first_port_pin_o        = st.a_out;
    assign first_port_pin_oe_o     = st.a_oe;
    assign fourth_port_pin_o       = st.d_out;
    assign fourth_port_pin_oe_o    = st.d_oe;
    assign timer_ext_clock_in_o    = st.tmr_clk;
    assign slave_data_o            = st.psp_byte;
    assign parallel_slave_enable_o = st.psp_en;
    assign converter_analog_o      = st.conv_cfg;

    // ************************************************************
    // Checks.
    // ************************************************************
    AST_A_DIR_DRIVE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        (wr_i && addr_i == `BPAD_OFS_A_DIR && wmask_i == 8'hFF)
        ##1 !rst_i && !wr_i
        |=> first_port_pin_oe_o[3:0] == ~$past(wdata_i[3:0], 2)
            && first_port_pin_oe_o[5] == ~$past(wdata_i[5], 2))
        else $error("Port A drive does not follow direction write.");

    AST_A_READ_ZERO: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && addr_i == `BPAD_OFS_A_DATA
        |=> rdata_o[7:6] == 2'h0 && rdata_o[5:0] == $past(a_read))
        else $error("Port A read is not the digital pin level.");

    AST_A_RMW: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && addr_i == `BPAD_OFS_A_DATA
        ##1 !rst_i && !wr_i
        |=> first_port_pin_o[3:0] ==
            (($past(a_pins[3:0], 2) & ~$past(wmask_i[3:0], 2)) | ($past(wdata_i[3:0], 2) & $past(wmask_i[3:0], 2))))
        else $error("Port A latch is not a read-modify-write result.");

    AST_OPEN_DRAIN: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        first_port_pin_oe_o[4] |-> first_port_pin_o[4] == 1'b0
            && $past(st.a_latch[4]) == 1'b0 && $past(st.a_dir[4]) == 1'b0)
        else $error("Open-drain bit drives while it should release.");

    AST_ANALOG_RESET: assert property (
        @(posedge sys_clk_i)
        rst_i ##1 !rst_i |-> converter_analog_o == `BPAD_RST_CONV_CFG)
        else $error("Port A pins are not analog after reset.");

    AST_D_DIR_RESET: assert property (
        @(posedge sys_clk_i)
        rst_i ##1 !rst_i |-> st.d_dir == `BPAD_RST_D_DIR ##1 fourth_port_pin_oe_o == 8'h00)
        else $error("Port D does not start as inputs.");

    AST_D_DRIVE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !st.psp_en && HAS_PORT_DE |=> fourth_port_pin_oe_o == ~$past(st.d_dir))
        else $error("Port D drive does not follow its direction bits.");

    AST_PSP_RELEASE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        st.psp_en |=> fourth_port_pin_oe_o == 8'h00 && slave_data_o == $past(d_pins))
        else $error("Slave mode does not pass the pin byte.");

    AST_REDUCED_ZERO: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !HAS_PORT_DE && rd_i && (addr_i == `BPAD_OFS_D_DATA || addr_i == `BPAD_OFS_D_DIR || addr_i == `BPAD_OFS_E_DIR)
        |=> rdata_o == 8'h00)
        else $error("Absent port D or E register does not read zero.");

    AST_E_UNUSED: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && addr_i == `BPAD_OFS_E_DIR |=> rdata_o[3] == 1'b0 && rdata_o[7:5] == 3'h0)
        else $error("Unused slave-status bits do not read zero.");

    AST_A_DIR_READ: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && addr_i == `BPAD_OFS_A_DIR |=> rdata_o == {2'h0, $past(st.a_dir)})
        else $error("Port A direction does not read back.");

    AST_A_DRIVE_DIR: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> first_port_pin_oe_o[3:0] == ~$past(st.a_dir[3:0])
            && first_port_pin_oe_o[5] == ~$past(st.a_dir[5]))
        else $error("Port A drive does not follow direction bits.");

    AST_A_OUT_LATCH: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> first_port_pin_o[3:0] == $past(st.a_latch[3:0])
            && first_port_pin_o[5] == $past(st.a_latch[5]))
        else $error("Port A outputs do not follow the latch.");

    AST_TMR_NO_HIGH: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        first_port_pin_o[`BPAD_A_TMR_BIT] == 1'b0)
        else $error("Open-drain bit drives high.");

    AST_TMR_CLOCK: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> timer_ext_clock_in_o == $past(a_pins[`BPAD_A_TMR_BIT]))
        else $error("Timer clock does not follow its pin.");

    AST_A_DIR_KEEP: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && addr_i == `BPAD_OFS_A_DATA |=> st.a_dir == $past(st.a_dir))
        else $error("Data write changes port A direction.");

    AST_RDATA_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !rd_i |=> $stable(rdata_o))
        else $error("Read data change without a read.");

    AST_UNMAPPED_ZERO: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && addr_i != `BPAD_OFS_A_DATA && addr_i != `BPAD_OFS_A_DIR && addr_i != `BPAD_OFS_CONV_CFG
            && addr_i != `BPAD_OFS_D_DATA && addr_i != `BPAD_OFS_D_DIR && addr_i != `BPAD_OFS_E_DIR
        |=> rdata_o == 8'h00)
        else $error("Unmapped address does not read zero.");

    AST_CONV_WRITE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && addr_i == `BPAD_OFS_CONV_CFG && wmask_i[4:0] == 5'h1F
        |=> converter_analog_o == $past(wdata_i[4:0]))
        else $error("Converter pin selection does not follow its write.");

    AST_ANALOG_READ: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        rd_i && addr_i == `BPAD_OFS_A_DATA
        |=> (rdata_o[3:0] & $past(converter_analog_o[3:0])) == 4'h0
            && !(rdata_o[5] && $past(converter_analog_o[4])))
        else $error("Analog pin does not read zero.");

    AST_D_RMW: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && addr_i == `BPAD_OFS_D_DATA
        ##1 !rst_i && !wr_i
        |=> fourth_port_pin_o == (($past(d_pins, 2) & ~$past(wmask_i, 2)) | ($past(wdata_i, 2) & $past(wmask_i, 2))))
        else $error("Port D latch is not a read-modify-write result.");

    AST_D_OUT_LATCH: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        1'b1 |=> fourth_port_pin_o == $past(st.d_latch))
        else $error("Port D outputs do not follow the latch.");

    AST_D_DIR_WRITE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && addr_i == `BPAD_OFS_D_DIR && wmask_i == 8'hFF |=> st.d_dir == $past(wdata_i))
        else $error("Port D direction does not take its write.");

    AST_D_DIR_READ: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        HAS_PORT_DE && rd_i && addr_i == `BPAD_OFS_D_DIR |=> rdata_o == $past(st.d_dir))
        else $error("Port D direction does not read back.");

    AST_PSP_SET: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        wr_i && addr_i == `BPAD_OFS_E_DIR && wmask_i[`BPAD_E_PSP_BIT]
        |=> parallel_slave_enable_o == $past(wdata_i[`BPAD_E_PSP_BIT]))
        else $error("Slave enable does not take its write.");

    AST_E_DIR_READ: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        HAS_PORT_DE && rd_i && addr_i == `BPAD_OFS_E_DIR
        |=> rdata_o[`BPAD_E_PSP_BIT] == $past(st.psp_en) && rdata_o[2:0] == $past(st.e_dir))
        else $error("Slave enable or port E direction does not read back.");

    AST_PSP_HOLD: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !st.psp_en |=> slave_data_o == $past(slave_data_o))
        else $error("Slave byte changes outside slave mode.");

    AST_REDUCED_NO_DRIVE: assert property (
        @(posedge sys_clk_i) disable iff (rst_i)
        !HAS_PORT_DE |-> fourth_port_pin_oe_o == 8'h00)
        else $error("Absent port D drives its pins.");

endmodule

// file: verif/bpad_pin_model.sv
// Purpose: Board model of the port pins with pull-ups.
// Assumes: A pin that the block drives wins over the board.
// Notes:   Pins that nobody drives float high.
`timescale 1ns/10ps
module bpad_pin_model #(
    parameter int W = 8
)
(
    // Block side.
    input  wire logic [W-1:0] dev_out_i,
    input  wire logic [W-1:0] dev_oe_i,
    // Board side.
    input  wire logic [W-1:0] ext_val_i,
    input  wire logic [W-1:0] ext_en_i,
    output logic      [W-1:0] level_o
);
    // Pins released by both the block and the board go to the pull-up level.
    always_comb begin
        for (int i = 0; i < W; i++) begin
            level_o[i] = dev_oe_i[i] ? dev_out_i[i] : (ext_en_i[i] ? ext_val_i[i] : 1'b1);
        end
    end
endmodule

// file: verif/tb.sv
// Purpose: Register and pin checks of the port block.
// Assumes: Read data one cycle after the strobe, pins settle in 8 cycles.
// Notes:   A second block without ports D and E shares the bus.
`timescale 1ns/10ps
`include "bpad_params.svh"
module tb;
    // ************************************************************
    // Signals.
    // ************************************************************
    logic       sys_clk_i, rst_i, wr_i, rd_i, tclk, psp;
    logic [7:0] addr_i, wdata_i, wmask_i, rdata_o, rdata2, pd_out, pd_oe, pd_lvl, pd_ext, pd_en, slave;
    logic [5:0] pa_out, pa_oe, pa_lvl, pa_ext, pa_en;
    logic [4:0] ana;
    int         fail_count, samples_checked;

    bpad_top dut (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i), .wr_i(wr_i), .rd_i(rd_i),
        .wdata_i(wdata_i), .wmask_i(wmask_i), .rdata_o(rdata_o), .first_port_pin_i(pa_lvl),
        .first_port_pin_o(pa_out), .first_port_pin_oe_o(pa_oe), .fourth_port_pin_i(pd_lvl),
        .fourth_port_pin_o(pd_out), .fourth_port_pin_oe_o(pd_oe), .timer_ext_clock_in_o(tclk),
        .slave_data_o(slave), .parallel_slave_enable_o(psp), .converter_analog_o(ana));
    bpad_top #(.HAS_PORT_DE(1'b0)) dut2 (.sys_clk_i(sys_clk_i), .rst_i(rst_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .wmask_i(wmask_i), .rdata_o(rdata2),
        .first_port_pin_i(pa_lvl), .first_port_pin_o(), .first_port_pin_oe_o(), .fourth_port_pin_i(pd_lvl),
        .fourth_port_pin_o(), .fourth_port_pin_oe_o(), .timer_ext_clock_in_o(), .slave_data_o(),
        .parallel_slave_enable_o(), .converter_analog_o());
    bpad_pin_model #(.W(6)) pins_a (.dev_out_i(pa_out), .dev_oe_i(pa_oe), .ext_val_i(pa_ext),
        .ext_en_i(pa_en), .level_o(pa_lvl));
    bpad_pin_model #(.W(8)) pins_d (.dev_out_i(pd_out), .dev_oe_i(pd_oe), .ext_val_i(pd_ext),
        .ext_en_i(pd_en), .level_o(pd_lvl));

    // ************************************************************
    // Tasks.
    // ************************************************************
    task automatic results();
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected %s: expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [7:0] m);
        @(posedge sys_clk_i);
        addr_i  <= a;
        wdata_i <= d;
        wmask_i <= m;
        wr_i    <= 1'b1;
        @(posedge sys_clk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string name);
        @(posedge sys_clk_i);
        addr_i <= a;
        rd_i   <= 1'b1;
        @(posedge sys_clk_i);
        rd_i <= 1'b0;
        #1;
        chk(name, exp, rdata_o);
        if (a == `BPAD_OFS_D_DATA || a == `BPAD_OFS_D_DIR || a == `BPAD_OFS_E_DIR) begin
            chk("reduced", 8'h00, rdata2);
        end
    endtask

    task automatic settle();
        repeat (8) @(posedge sys_clk_i);
        #1;
    endtask

    // ************************************************************
    // Sequence.
    // ************************************************************
    initial begin
        sys_clk_i = 1'b0;
        forever #4 sys_clk_i = ~sys_clk_i;
    end

    initial begin
        repeat (20000) @(posedge sys_clk_i);
        fail_count++;
        $display("unexpected timeout: expected end seen hang");
        results();
    end

    initial begin
        rst_i = 1'b1;
        wr_i = 1'b0;
        rd_i = 1'b0;
        addr_i = 8'h00;
        wdata_i = 8'h00;
        wmask_i = 8'h00;
        pa_ext = 6'h3F;
        pa_en = 6'h3F;
        pd_ext = 8'h00;
        pd_en = 8'hFF;
        fail_count = 0;
        samples_checked = 0;
        repeat (5) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        settle();
        chk("a oe rst", 8'h00, {2'b00, pa_oe});
        chk("d oe rst", 8'h00, pd_oe);
        chk("analog rst", 8'h1F, {3'b000, ana});
        chk("slave rst", 8'h00, {7'h00, psp});
        rd(`BPAD_OFS_D_DIR, 8'hFF, "d dir rst");
        rd(`BPAD_OFS_E_DIR, 8'h07, "e dir rst");
        rd(`BPAD_OFS_A_DIR, 8'h3F, "a dir rst");
        rd(`BPAD_OFS_A_DATA, 8'h10, "a analog");
        rd(8'h07, 8'h00, "unmapped");
        // Port A digital, read-modify-write and open drain.
        wr(`BPAD_OFS_CONV_CFG, 8'h00, 8'hFF);
        pa_ext <= 6'h15;
        settle();
        rd(`BPAD_OFS_A_DATA, 8'h15, "a pins");
        wr(`BPAD_OFS_A_DATA, 8'h00, 8'h01);
        settle();
        chk("a oe input", 8'h00, {2'b00, pa_oe});
        pa_en <= 6'h00;
        wr(`BPAD_OFS_A_DIR, 8'h00, 8'hFF);
        settle();
        chk("a oe out", 8'h2F, {2'b00, pa_oe});
        chk("a out", 8'h04, {2'b00, pa_out});
        chk("timer clk hi", 8'h01, {7'h00, tclk});
        rd(`BPAD_OFS_A_DATA, 8'h14, "a rmw");
        wr(`BPAD_OFS_A_DATA, 8'h00, 8'h10);
        settle();
        chk("a oe low", 8'h3F, {2'b00, pa_oe});
        chk("timer clk lo", 8'h00, {7'h00, tclk});
        rd(`BPAD_OFS_A_DATA, 8'h04, "a low");
        wr(`BPAD_OFS_A_DIR, 8'h3F, 8'hFF);
        settle();
        chk("a oe back", 8'h00, {2'b00, pa_oe});
        // Port D as general I/O.
        pd_en <= 8'hF0;
        pd_ext <= 8'hA0;
        wr(`BPAD_OFS_D_DIR, 8'hF0, 8'hFF);
        wr(`BPAD_OFS_D_DATA, 8'h0F, 8'hFF);
        settle();
        chk("d oe", 8'h0F, pd_oe);
        chk("d out", 8'h0F, pd_out);
        rd(`BPAD_OFS_D_DATA, 8'hAF, "d pins");
        rd(`BPAD_OFS_D_DIR, 8'hF0, "d dir");
        // Port D in slave mode.
        wr(`BPAD_OFS_E_DIR, 8'hFF, 8'hFF);
        pd_en <= 8'hFF;
        pd_ext <= 8'h5A;
        settle();
        chk("slave en", 8'h01, {7'h00, psp});
        chk("d oe slave", 8'h00, pd_oe);
        chk("slave byte", 8'h5A, slave);
        rd(`BPAD_OFS_E_DIR, 8'h17, "e flags");
        // Second reset in mid-run.
        @(posedge sys_clk_i);
        rst_i <= 1'b1;
        repeat (2) @(posedge sys_clk_i);
        rst_i <= 1'b0;
        settle();
        chk("slave rst2", 8'h00, {7'h00, psp});
        chk("analog rst2", 8'h1F, {3'b000, ana});
        rd(`BPAD_OFS_D_DIR, 8'hFF, "d dir rst2");
        results();
    end
endmodule
